/* File: design/wdpm_pkg.sv */
package wdpm_pkg;
	// Port command function codes
	localparam logic [3:0] OP_SW_RESET   = 4'h0;
	localparam logic [3:0] OP_SELF_TEST  = 4'h1;
	localparam logic [3:0] OP_SEL_RESET  = 4'h2;
	localparam logic [3:0] OP_DUMP       = 4'h3;
	localparam logic [3:0] OP_WAKE_DUMP  = 4'h7;
	localparam int         OPCODE_MSB    = 3;
	localparam int         PTR_LSB       = 4;
	// Dump area layout, doubleword indices
	localparam logic [1:0] DW_STATUS     = 2'h0;
	localparam logic [1:0] DW_COUNT      = 2'h1;
	localparam logic [1:0] DW_DATA       = 2'h2;
	localparam logic [31:0] DUMP_STATUS_OK = 32'h0000A000;
	localparam logic [7:0]  COUNT_OVERLONG = 8'hFF;
	localparam int          MAX_POST_BYTES = 120;
	// Power states
	localparam logic [1:0] PS_D0 = 2'h0;
	localparam logic [1:0] PS_D3 = 2'h3;
	// Driver-side register map
	localparam logic [3:0] REG_PORT      = 4'h0;
	localparam logic [3:0] REG_WAKE_IND  = 4'h1;
	localparam logic [3:0] REG_WAKE_CFG  = 4'h2;
	localparam logic [3:0] REG_PM_STATE  = 4'h3;
	// Wake indication bits
	localparam int IND_LINK     = 0;
	localparam int IND_MAGIC    = 1;
	localparam int IND_FRAME    = 2;
	localparam int IND_PME_STAT = 3;
	// Wake config bits
	localparam int CFG_LINK_EN  = 0;
	localparam int CFG_MAGIC_EN = 1;
	localparam int CFG_FRAME_EN = 2;
endpackage

/* File: design/wdpm_frame_store.sv */
`timescale 1ns/1ps
// Retained wake frame, flip-flop storage written bytewise, read by word
module wdpm_frame_store
	import wdpm_pkg::*;
#(
	parameter int DEPTH = 120
)(
	input  wire logic                     i_mclk,
	input  wire logic                     i_reset,
	input  wire logic                     i_clear,
	input  wire logic                     i_wr,
	input  wire logic [7:0]               i_byte,
	input  wire logic [$clog2(DEPTH)-1:0] i_rd_word,
	output logic [31:0]                   o_word,
	output logic [7:0]                    o_len
);
	initial
	begin
		if (DEPTH % 4 != 0 || DEPTH > 252)
			$error("frame store depth unsupported");
	end
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][7:0] mem;
		logic [7:0]            len;
		logic [31:0]           word;
	} wdpm_fs_t;
	wdpm_fs_t st_q, st_d;
	logic [AW-1:0] base;
	always_comb
	begin
		st_d = st_q;
		base = AW'({i_rd_word, 2'b00});
		if (i_clear)
			st_d.len = 8'h00;
		else if (i_wr)
		begin
			// Bytes past capacity are counted but dropped
			if (st_q.len < 8'(DEPTH))
				st_d.mem[st_q.len[AW-1:0]] = i_byte;
			if (st_q.len != 8'hFF)
				st_d.len = st_q.len + 8'h01;
		end
		for (int b = 0; b < 4; b++)
			st_d.word[b*8 +: 8] = st_q.mem[base + AW'(b)];
	end
	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
		begin
			st_q.len  <= 8'h00;
			st_q.word <= 32'h0;
		end
		else
		begin
			st_q.len  <= st_d.len;
			st_q.word <= st_d.word;
		end
		st_q.mem <= st_d.mem;
	end
	assign o_word = st_q.word;
	assign o_len  = st_q.len;
endmodule

/* File: design/wdpm_pme_ctrl.sv */
`timescale 1ns/1ps
// Power-event status, wake indications and PHY power control
module wdpm_pme_ctrl
	import wdpm_pkg::*;
(
	input  wire logic       i_mclk,
	input  wire logic       i_reset,
	input  wire logic [1:0] i_pstate,
	input  wire logic       i_pme_en,
	input  wire logic       i_deep_pd_en,
	input  wire logic       i_link_up,
	input  wire logic [2:0] i_wake_en,
	input  wire logic       i_magic_hit,
	input  wire logic       i_frame_hit,
	input  wire logic       i_pmcsr_clr,
	input  wire logic [3:0] i_ind_clr,
	output logic [3:0]      o_ind,
	output logic            o_phy_off,
	output logic            o_pme
);
	typedef struct packed {
		logic [3:0] ind;
		logic       phy_off;
		logic       link_prev;
		logic       pme;
	} wdpm_pm_t;
	wdpm_pm_t st_q, st_d;
	logic link_ev, magic_ev, frame_ev;
	always_comb
	begin
		st_d = st_q;
		st_d.link_prev = i_link_up;
		// Link change wakes in every power state while the PHY is on, frames only outside D0
		link_ev  = i_wake_en[CFG_LINK_EN] && !st_q.phy_off && (i_link_up != st_q.link_prev);
		magic_ev = i_wake_en[CFG_MAGIC_EN] && i_magic_hit && i_pstate != PS_D0;
		frame_ev = i_wake_en[CFG_FRAME_EN] && i_frame_hit && i_pstate != PS_D0;
		// Clear first so a same-cycle event survives
		st_d.ind = st_q.ind & ~i_ind_clr;
		if (i_pmcsr_clr)
			st_d.ind[IND_PME_STAT] = 1'b0;
		if (link_ev)
			st_d.ind[IND_LINK] = 1'b1;
		if (magic_ev)
			st_d.ind[IND_MAGIC] = 1'b1;
		if (frame_ev)
			st_d.ind[IND_FRAME] = 1'b1;
		if (link_ev || magic_ev || frame_ev)
			st_d.ind[IND_PME_STAT] = 1'b1;
		if (i_pstate == PS_D3 && !i_pme_en && i_deep_pd_en)
			st_d.phy_off = 1'b1;
		else if (i_pme_en)
			st_d.phy_off = 1'b0;
		st_d.pme = st_d.ind[IND_PME_STAT] && i_pme_en;
	end
	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
			st_q <= '0;
		else
			st_q <= st_d;
	end
	assign o_ind     = st_q.ind;
	assign o_phy_off = st_q.phy_off;
	assign o_pme     = st_q.pme;

	property p_pme_hold;
		@(posedge i_mclk) disable iff (i_reset)
		(o_ind[IND_PME_STAT] && i_pme_en && !i_pmcsr_clr && !i_ind_clr[IND_PME_STAT]) |=> o_pme;
	endproperty
	a_pme_hold: assert property (p_pme_hold) else $error("power event dropped while status set");
	property p_frame_both;
		@(posedge i_mclk) disable iff (i_reset)
		frame_ev |=> (o_ind[IND_FRAME] && o_ind[IND_PME_STAT]);
	endproperty
	a_frame_both: assert property (p_frame_both) else $error("frame bits not set together");
	property p_d0_no_frame;
		@(posedge i_mclk) disable iff (i_reset)
		(i_pstate == PS_D0 && !o_ind[IND_FRAME] && !i_frame_hit && !i_magic_hit) ##0 (i_pstate == PS_D0)
			|=> !o_ind[IND_FRAME];
	endproperty
	a_d0_no_frame: assert property (p_d0_no_frame) else $error("frame wake in D0");
	property p_deep_pd;
		@(posedge i_mclk) disable iff (i_reset)
		(i_pstate == PS_D3 && !i_pme_en && i_deep_pd_en) |=> o_phy_off;
	endproperty
	a_deep_pd: assert property (p_deep_pd) else $error("phy not off in deep power-down");
	property p_phy_on;
		@(posedge i_mclk) disable iff (i_reset)
		i_pme_en |=> !o_phy_off;
	endproperty
	a_phy_on: assert property (p_phy_on) else $error("phy not restored");
	property p_pmcsr_clr;
		@(posedge i_mclk) disable iff (i_reset)
		(i_pmcsr_clr && !link_ev && !magic_ev && !frame_ev) |=> !o_ind[IND_PME_STAT];
	endproperty
	a_pmcsr_clr: assert property (p_pmcsr_clr) else $error("status copy not cleared");
endmodule

/* File: design/wdpm_top.sv */
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
// Behaviour
// - Port command function code sits in low four bits; five codes defined.
// - Wake dump copies retained frame to host memory at the pointer.
// - First dump write puts frame byte count into doubleword 1.
// - Frames over 120 bytes post 120 bytes and report count FFh.
// - Frame bytes follow from doubleword 2.
// - Last dump write puts A000h into doubleword 0.
// - Wake dump also applies internal selective reset.
// - Matching frame sets interesting-frame and power-event status together.
// - Frame lives in counter storage; driver must dump-reset counters after.
// - Magic frame may raise event but is never retained.
// - D3, events disabled, deep power-down enabled: PHY switched off.
// - D0 wakes on link change only; frames wake in D1 to D3.
// - Event enable after PHY off powers PHY up; link then raises event.
// - Power-event output held until status bit cleared.
// - Three clearable wake bits: link change, magic, interesting frame.
// - Clear through power-management register shows in driver-side copy.
module wdpm_top
	import wdpm_pkg::*;
#(
	parameter int FRAME_BYTES = MAX_POST_BYTES
)(
	input  wire logic        i_mclk,
	input  wire logic        i_reset,
	// Driver register port
	input  wire logic [3:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic [31:0]      o_rdata,
	// PCI power management
	input  wire logic [1:0]  i_pstate,
	input  wire logic        i_pme_en,
	input  wire logic        i_pmcsr_clr,
	input  wire logic        i_deep_pd_en,
	output logic             o_pme,
	// Receive side
	input  wire logic        i_link_up,
	input  wire logic        i_rx_valid,
	input  wire logic [7:0]  i_rx_byte,
	input  wire logic        i_rx_start,
	input  wire logic        i_rx_wake_hit,
	input  wire logic        i_rx_magic_hit,
	output logic             o_phy_off,
	// Host memory writes
	output logic             o_mem_wr,
	output logic [31:0]      o_mem_addr,
	output logic [31:0]      o_mem_data,
	input  wire logic        i_mem_ready,
	// Unit control
	output logic             o_sel_reset,
	output logic             o_sw_reset,
	output logic             o_self_test,
	output logic             o_stat_dump
);
	initial
	begin
		if (FRAME_BYTES != MAX_POST_BYTES)
			$error("frame store must hold the posted limit");
	end
	localparam int WAW = $clog2(FRAME_BYTES);
	localparam int NWORDS = FRAME_BYTES / 4;

	typedef enum logic [2:0] {
		S_IDLE   = 3'b000,
		S_COUNT  = 3'b001,
		S_FETCH  = 3'b010,
		S_DATA   = 3'b011,
		S_STATUS = 3'b100
	} wdpm_state_t;

	typedef struct packed {
		wdpm_state_t  st;
		logic [27:0]  ptr;
		logic [7:0]   posted;
		logic [7:0]   count;
		logic [WAW-1:0] widx;
		logic         capture;
		logic [2:0]   wake_cfg;
		logic         mem_wr;
		logic [31:0]  mem_addr;
		logic [31:0]  mem_data;
		logic [31:0]  rdata;
		logic         sel_reset;
		logic         sw_reset;
		logic         self_test;
		logic         stat_dump;
	} wdpm_top_t;

	wdpm_top_t s_q, s_d;
	logic [31:0] fs_word;
	logic [7:0]  fs_len;
	logic [3:0]  ind;
	logic [3:0]  ind_clr;
	logic        fs_wr;
	logic        fs_clear;
	logic        port_wr;

	function automatic logic [31:0] dump_addr(input logic [27:0] ptr, input logic [7:0] dw);
		dump_addr = {ptr, 4'h0} + {22'h0, dw, 2'b00};
	endfunction

	assign port_wr = i_wr && i_addr == REG_PORT;
	// Store is reloaded at each new candidate frame; magic frames never keep it
	assign fs_clear = i_rx_start && s_q.st == S_IDLE && !s_q.capture;
	assign fs_wr    = i_rx_valid && !s_q.capture && s_q.st == S_IDLE && i_pstate != PS_D0;
	assign ind_clr  = (i_wr && i_addr == REG_WAKE_IND) ? i_wdata[3:0] : 4'h0;

	wdpm_frame_store #(
		.DEPTH(FRAME_BYTES)
	) u_store (
		.i_mclk   (i_mclk),
		.i_reset  (i_reset),
		.i_clear  (fs_clear),
		.i_wr     (fs_wr),
		.i_byte   (i_rx_byte),
		.i_rd_word(s_q.widx),
		.o_word   (fs_word),
		.o_len    (fs_len)
	);

	wdpm_pme_ctrl u_pme (
		.i_mclk      (i_mclk),
		.i_reset     (i_reset),
		.i_pstate    (i_pstate),
		.i_pme_en    (i_pme_en),
		.i_deep_pd_en(i_deep_pd_en),
		.i_link_up   (i_link_up),
		.i_wake_en   (s_q.wake_cfg),
		.i_magic_hit (i_rx_magic_hit),
		.i_frame_hit (i_rx_wake_hit),
		.i_pmcsr_clr (i_pmcsr_clr),
		.i_ind_clr   (ind_clr),
		.o_ind       (ind),
		.o_phy_off   (o_phy_off),
		.o_pme       (o_pme)
	);

	always_comb
	begin
		s_d = s_q;
		s_d.sel_reset = 1'b0;
		s_d.sw_reset  = 1'b0;
		s_d.self_test = 1'b0;
		s_d.stat_dump = 1'b0;
		s_d.rdata     = 32'h0;
		// A matching frame freezes the store until the dump
		if (i_rx_wake_hit && i_pstate != PS_D0 && s_q.wake_cfg[CFG_FRAME_EN])
			s_d.capture = 1'b1;
		if (i_rd)
		begin
			unique case (i_addr)
				REG_WAKE_IND: s_d.rdata = {28'h0, ind};
				REG_WAKE_CFG: s_d.rdata = {29'h0, s_q.wake_cfg};
				REG_PM_STATE: s_d.rdata = {27'h0, o_phy_off, (s_q.st != S_IDLE), 1'b0, i_pstate};
				default:      s_d.rdata = 32'h0;
			endcase
		end
		if (i_wr && i_addr == REG_WAKE_CFG)
			s_d.wake_cfg = i_wdata[2:0];
		if (s_q.mem_wr && i_mem_ready)
			s_d.mem_wr = 1'b0;
		unique case (s_q.st)
			S_IDLE:
			begin
				if (port_wr)
				begin
					unique case (i_wdata[OPCODE_MSB:0])
						OP_SW_RESET:  s_d.sw_reset  = 1'b1;
						OP_SELF_TEST: s_d.self_test = 1'b1;
						OP_SEL_RESET: s_d.sel_reset = 1'b1;
						OP_DUMP:      s_d.stat_dump = 1'b1;
						OP_WAKE_DUMP:
						begin
							s_d.ptr = i_wdata[31:PTR_LSB];
							s_d.sel_reset = 1'b1;
							s_d.st = S_COUNT;
						end
						default: ;
					endcase
				end
			end
			S_COUNT:
			begin
				// A status write of the last dump may still be pending
				if (!s_q.mem_wr || i_mem_ready)
				begin
					// Overlong frames are truncated to the store size
					if (fs_len > 8'(MAX_POST_BYTES))
					begin
						s_d.count  = COUNT_OVERLONG;
						s_d.posted = 8'(MAX_POST_BYTES);
					end
					else
					begin
						s_d.count  = fs_len;
						s_d.posted = fs_len;
					end
					s_d.mem_wr   = 1'b1;
					s_d.mem_addr = dump_addr(s_q.ptr, {6'h0, DW_COUNT});
					s_d.mem_data = {24'h0, s_d.count};
					s_d.widx     = '0;
					s_d.st       = S_FETCH;
				end
			end
			S_FETCH:
			begin
				// Wait at least one cycle for the store's registered word, and until any pending write is accepted
				if (!s_q.mem_wr || i_mem_ready)
					s_d.st = ({s_q.widx, 2'b00} >= 10'(s_q.posted)) ? S_STATUS : S_DATA;
			end
			S_DATA:
			begin
				s_d.mem_wr   = 1'b1;
				s_d.mem_addr = dump_addr(s_q.ptr, 8'(DW_DATA) + 8'(s_q.widx));
				s_d.mem_data = fs_word;
				s_d.widx     = (32'(s_q.widx) + 1 < NWORDS) ? s_q.widx + WAW'(1) : s_q.widx;
				s_d.st       = S_FETCH;
				if (32'(s_q.widx) + 1 >= NWORDS)
					s_d.posted = 8'h00;
			end
			S_STATUS:
			begin
				if (!s_q.mem_wr || i_mem_ready)
				begin
					s_d.mem_wr   = 1'b1;
					s_d.mem_addr = dump_addr(s_q.ptr, {6'h0, DW_STATUS});
					s_d.mem_data = DUMP_STATUS_OK;
					s_d.capture  = 1'b0;
					// Counters held the frame; driver must dump-reset them now
					s_d.st       = S_IDLE;
				end
			end
			default: s_d.st = S_IDLE;
		endcase
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign o_rdata     = s_q.rdata;
	assign o_mem_wr    = s_q.mem_wr;
	assign o_mem_addr  = s_q.mem_addr;
	assign o_mem_data  = s_q.mem_data;
	assign o_sel_reset = s_q.sel_reset;
	assign o_sw_reset  = s_q.sw_reset;
	assign o_self_test = s_q.self_test;
	assign o_stat_dump = s_q.stat_dump;

	sequence s_wd_cmd;
		port_wr && i_wdata[OPCODE_MSB:0] == OP_WAKE_DUMP && s_q.st == S_IDLE;
	endsequence
	sequence s_wd_free_cmd;
		port_wr && i_wdata[OPCODE_MSB:0] == OP_WAKE_DUMP && s_q.st == S_IDLE && !s_q.mem_wr;
	endsequence
	property p_wd_first_count;
		@(posedge i_mclk) disable iff (i_reset)
		s_wd_free_cmd |=> ##1 (o_mem_wr && o_mem_addr == {s_q.ptr, 4'h0} + 32'h4);
	endproperty
	a_wd_first_count: assert property (p_wd_first_count) else $error("count not first write");
	property p_wd_selreset;
		@(posedge i_mclk) disable iff (i_reset)
		s_wd_cmd |=> o_sel_reset;
	endproperty
	a_wd_selreset: assert property (p_wd_selreset) else $error("no selective reset on wake dump");
	property p_overlong;
		@(posedge i_mclk) disable iff (i_reset)
		(s_q.st == S_COUNT && fs_len > 8'(MAX_POST_BYTES)) |=> (o_mem_data == 32'h000000FF);
	endproperty
	a_overlong: assert property (p_overlong) else $error("overlong count wrong");
	property p_status_last;
		@(posedge i_mclk) disable iff (i_reset)
		(s_q.st == S_STATUS && $past(s_q.st) == S_STATUS) or (s_q.st == S_STATUS && (!s_q.mem_wr || i_mem_ready))
			|=> (o_mem_data == DUMP_STATUS_OK && s_q.st == S_IDLE);
	endproperty
	a_status_last: assert property (p_status_last) else $error("status word not final");
	property p_data_area;
		@(posedge i_mclk) disable iff (i_reset)
		(s_q.st == S_DATA) |=> (o_mem_wr && o_mem_addr >= {s_q.ptr, 4'h0} + 32'h8);
	endproperty
	a_data_area: assert property (p_data_area) else $error("data below doubleword 2");
	property p_opcode;
		@(posedge i_mclk) disable iff (i_reset)
		(port_wr && s_q.st == S_IDLE && i_wdata[OPCODE_MSB:0] == OP_SW_RESET) |=> (o_sw_reset && !o_sel_reset);
	endproperty
	a_opcode: assert property (p_opcode) else $error("opcode decode wrong");
	property p_self_test_op;
		@(posedge i_mclk) disable iff (i_reset)
		(port_wr && s_q.st == S_IDLE && i_wdata[OPCODE_MSB:0] == OP_SELF_TEST) |=> (o_self_test && !o_sel_reset);
	endproperty
	a_self_test_op: assert property (p_self_test_op) else $error("self test decode wrong");
	property p_sel_reset_op;
		@(posedge i_mclk) disable iff (i_reset)
		(port_wr && s_q.st == S_IDLE && i_wdata[OPCODE_MSB:0] == OP_SEL_RESET) |=> (o_sel_reset && !o_sw_reset);
	endproperty
	a_sel_reset_op: assert property (p_sel_reset_op) else $error("selective reset decode wrong");
	property p_dump_op;
		@(posedge i_mclk) disable iff (i_reset)
		(port_wr && s_q.st == S_IDLE && i_wdata[OPCODE_MSB:0] == OP_DUMP) |=> (o_stat_dump && !o_sel_reset);
	endproperty
	a_dump_op: assert property (p_dump_op) else $error("dump decode wrong");
	property p_busy_ignore;
		@(posedge i_mclk) disable iff (i_reset)
		(port_wr && s_q.st != S_IDLE) |=> (!o_sw_reset && !o_self_test && !o_stat_dump);
	endproperty
	a_busy_ignore: assert property (p_busy_ignore) else $error("command taken during dump");
	property p_count_value;
		@(posedge i_mclk) disable iff (i_reset)
		(s_q.st == S_COUNT && !s_q.mem_wr && fs_len <= 8'(MAX_POST_BYTES)) |=> (o_mem_data == {24'h0, $past(fs_len)});
	endproperty
	a_count_value: assert property (p_count_value) else $error("byte count wrong");
	property p_frame_held;
		@(posedge i_mclk) disable iff (i_reset)
		s_q.capture |=> $stable(fs_len);
	endproperty
	a_frame_held: assert property (p_frame_held) else $error("held frame disturbed");
	property p_capture_set;
		@(posedge i_mclk) disable iff (i_reset)
		(i_rx_wake_hit && i_pstate != PS_D0 && s_q.wake_cfg[CFG_FRAME_EN] && s_q.st == S_IDLE) |=> s_q.capture;
	endproperty
	a_capture_set: assert property (p_capture_set) else $error("matching frame not held");
	property p_magic_no_keep;
		@(posedge i_mclk) disable iff (i_reset)
		(i_rx_magic_hit && !i_rx_wake_hit && !s_q.capture) |=> !s_q.capture;
	endproperty
	a_magic_no_keep: assert property (p_magic_no_keep) else $error("magic frame retained");
	property p_mem_hold;
		@(posedge i_mclk) disable iff (i_reset)
		(o_mem_wr && !i_mem_ready) |=> (o_mem_wr && $stable(o_mem_addr) && $stable(o_mem_data));
	endproperty
	a_mem_hold: assert property (p_mem_hold) else $error("memory write changed before accepted");
	property p_fetch_wait;
		@(posedge i_mclk) disable iff (i_reset)
		(s_q.st == S_FETCH && o_mem_wr && !i_mem_ready) |=> (s_q.st == S_FETCH);
	endproperty
	a_fetch_wait: assert property (p_fetch_wait) else $error("data word issued over pending write");
endmodule

/* File: bench/wdpm_host_mem.sv */
`timescale 1ns/1ps
// Host memory: ready i_lat+1 cycles after a write appears, one cycle long; logs accepted writes
module wdpm_host_mem
(
	input  wire logic        i_mclk,
	input  wire logic        i_wr,
	input  wire logic [31:0] i_addr,
	input  wire logic [31:0] i_data,
	input  wire logic [1:0]  i_lat,
	output logic             o_ready
);
	logic [31:0] log_a[$];
	logic [31:0] log_d[$];
	logic [1:0]  wait_q;
	initial
	begin
		o_ready = 1'b0;
		wait_q = 2'h0;
	end
	always @(posedge i_mclk)
	begin
		if (i_wr && o_ready)
		begin
			log_a.push_back(i_addr);
			log_d.push_back(i_data);
			o_ready <= 1'b0;
			wait_q <= 2'h0;
		end
		else if (i_wr && wait_q >= i_lat)
			o_ready <= 1'b1;
		else if (i_wr)
			wait_q <= wait_q + 2'h1;
	end
endmodule

/* File: bench/wdpm_top_tb.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_mismatch++; \
	$display("BAD %0t got %h exp %h", $time, (a), (e)); end end
module wdpm_top_tb
	import wdpm_pkg::*;
;
	logic        i_mclk, i_reset, i_wr, i_rd, i_pme_en, i_pmcsr_clr, i_deep_pd_en;
	logic        i_link_up, i_rx_valid, i_rx_start, i_rx_wake_hit, i_rx_magic_hit, i_mem_ready;
	logic [3:0]  i_addr;
	logic [31:0] i_wdata, o_rdata, o_mem_addr, o_mem_data, rv;
	logic [1:0]  i_pstate, lat;
	logic [7:0]  i_rx_byte;
	logic        o_pme, o_phy_off, o_mem_wr, o_sel_reset, o_sw_reset, o_self_test, o_stat_dump;
	int          n_mismatch = 0;
	int          samples_checked = 0;
	int          pc[4] = '{0, 0, 0, 0};
	int          pv[4];
	wdpm_top dut (.i_mclk(i_mclk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
		.i_rd(i_rd), .o_rdata(o_rdata), .i_pstate(i_pstate), .i_pme_en(i_pme_en),
		.i_pmcsr_clr(i_pmcsr_clr), .i_deep_pd_en(i_deep_pd_en), .o_pme(o_pme), .i_link_up(i_link_up),
		.i_rx_valid(i_rx_valid), .i_rx_byte(i_rx_byte), .i_rx_start(i_rx_start),
		.i_rx_wake_hit(i_rx_wake_hit), .i_rx_magic_hit(i_rx_magic_hit), .o_phy_off(o_phy_off),
		.o_mem_wr(o_mem_wr), .o_mem_addr(o_mem_addr), .o_mem_data(o_mem_data), .i_mem_ready(i_mem_ready),
		.o_sel_reset(o_sel_reset), .o_sw_reset(o_sw_reset), .o_self_test(o_self_test),
		.o_stat_dump(o_stat_dump));
	wdpm_host_mem mem (.i_mclk(i_mclk), .i_wr(o_mem_wr), .i_addr(o_mem_addr), .i_data(o_mem_data),
		.i_lat(lat), .o_ready(i_mem_ready));
	initial
	begin
		i_mclk = 1'b0;
		forever #12.5 i_mclk = ~i_mclk;
	end
	always @(posedge i_mclk)
	begin
		if (o_sw_reset === 1'b1) pc[0]++;
		if (o_self_test === 1'b1) pc[1]++;
		if (o_sel_reset === 1'b1) pc[2]++;
		if (o_stat_dump === 1'b1) pc[3]++;
	end
	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge i_mclk);
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge i_mclk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_mclk);
		i_wr <= 1'b0;
	endtask
	task automatic chk_reg(input logic [3:0] a, input logic [31:0] e);
		@(posedge i_mclk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1 `CHK(o_rdata, e)
	endtask
	task automatic pm(input logic [1:0] ps, input logic en);
		@(posedge i_mclk);
		i_pstate <= ps;
		i_pme_en <= en;
	endtask
	task automatic wake_clr();
		@(posedge i_mclk);
		i_pmcsr_clr <= 1'b1;
		@(posedge i_mclk);
		i_pmcsr_clr <= 1'b0;
		wr_reg(REG_WAKE_IND, 32'h0000000F);
	endtask
	function automatic logic [7:0] fb(input int i);
		return 8'(i * 7 + 8'h21);
	endfunction
	task automatic send(input int n, input logic hit, input logic mag);
		@(posedge i_mclk);
		i_rx_start <= 1'b1;
		for (int i = 0; i < n; i++)
		begin
			@(posedge i_mclk);
			i_rx_start <= 1'b0;
			i_rx_valid <= 1'b1;
			i_rx_byte <= fb(i);
		end
		@(posedge i_mclk);
		i_rx_valid <= 1'b0;
		i_rx_wake_hit <= hit;
		i_rx_magic_hit <= mag;
		@(posedge i_mclk);
		i_rx_wake_hit <= 1'b0;
		i_rx_magic_hit <= 1'b0;
		cyc(3);
	endtask
	task automatic dump(input int n, input logic [31:0] ptr);
		int          posted, words, k, s;
		logic [31:0] w;
		mem.log_a.delete();  // Write log emptied first
		mem.log_d.delete();
		s = pc[2];
		posted = (n > 120) ? 120 : n;
		words = posted / 4;
		wr_reg(REG_PORT, {ptr[31:4], OP_WAKE_DUMP});
		k = 0;
		while (mem.log_a.size() < words + 2 && k < 4000)
		begin
			cyc(1);
			k++;
		end
		`CHK(mem.log_a.size(), words + 2)
		`CHK(mem.log_a[0], ptr + 32'h4)
		`CHK(mem.log_d[0], {24'h0, (n > 120) ? 8'hFF : 8'(n)})
		for (int i = 0; i < words; i++)
		begin
			w = {fb(4 * i + 3), fb(4 * i + 2), fb(4 * i + 1), fb(4 * i)};
			`CHK(mem.log_a[i + 1], ptr + 32'h8 + 32'(4 * i))
			`CHK(mem.log_d[i + 1], w)
		end
		`CHK(mem.log_a[words + 1], ptr)
		`CHK(mem.log_d[words + 1], 32'h0000A000)
		`CHK(pc[2] - s, 1)
	endtask
	initial
	begin
		#(25ns * 20000);
		n_mismatch++;
		$display("BAD %0t watchdog expired", $time);
		conclude();
	end
	initial
	begin
		{i_wr, i_rd, i_pme_en, i_pmcsr_clr, i_deep_pd_en, i_link_up} = 6'h00;
		{i_rx_valid, i_rx_start, i_rx_wake_hit, i_rx_magic_hit} = 4'h0;
		i_addr = 4'h0;
		i_wdata = 32'h0;
		i_pstate = 2'h0;
		i_rx_byte = 8'h00;
		lat = 2'h0;
		i_reset = 1'b1;
		cyc(10);
		i_reset <= 1'b0;
		chk_reg(REG_WAKE_IND, 32'h0);
		chk_reg(REG_WAKE_CFG, 32'h0);
		chk_reg(4'h9, 32'h0);
		`CHK(o_pme, 1'b0)
		for (int i = 0; i < 4; i++)
		begin
			pv = pc;
			wr_reg(REG_PORT, {28'h0, 4'(i)});
			cyc(3);
			for (int j = 0; j < 4; j++)
				`CHK(pc[j], pv[j] + (i == j))
		end
		wr_reg(REG_WAKE_CFG, 32'h00000007);
		chk_reg(REG_WAKE_CFG, 32'h00000007);
		send(12, 1'b1, 1'b0);
		chk_reg(REG_WAKE_IND, 32'h0);
		pm(PS_D3, 1'b1);  // Enable and state together
		send(12, 1'b1, 1'b0);
		chk_reg(REG_WAKE_IND, 32'h0000000C);
		`CHK(o_pme, 1'b1)
		pm(PS_D0, 1'b1);
		cyc(3);
		`CHK(o_pme, 1'b1)
		@(posedge i_mclk);
		i_pmcsr_clr <= 1'b1;
		@(posedge i_mclk);
		i_pmcsr_clr <= 1'b0;
		cyc(3);
		`CHK(o_pme, 1'b0)
		chk_reg(REG_WAKE_IND, 32'h00000004);
		wr_reg(REG_WAKE_IND, 32'h0000000F);
		chk_reg(REG_WAKE_IND, 32'h0);
		dump(12, 32'h00001230);  // Flagged frame dumped
		lat <= 2'h3;
		pm(2'h2, 1'b1);
		send(130, 1'b1, 1'b0);
		send(8, 1'b0, 1'b0);  // Later frame must not disturb held one
		pm(PS_D0, 1'b1);
		wake_clr();
		dump(130, 32'h00002000);
		pm(PS_D3, 1'b1);
		send(12, 1'b0, 1'b1);
		chk_reg(REG_WAKE_IND, 32'h0000000A);
		pm(PS_D0, 1'b1);
		wake_clr();
		i_deep_pd_en <= 1'b1;
		pm(PS_D3, 1'b0);  // Enable cleared with D3 entry
		cyc(3);
		`CHK(o_phy_off, 1'b1)
		chk_reg(REG_PM_STATE, 32'h00000013);
		pm(PS_D3, 1'b1);
		cyc(3);
		`CHK(o_phy_off, 1'b0)
		i_link_up <= 1'b1;
		cyc(6);
		chk_reg(REG_WAKE_IND, 32'h00000009);
		`CHK(o_pme, 1'b1)
		conclude();
	end
endmodule
